/* File: smc_ctrl.v */
// Purpose: sleep-mode controller, clock gating and wake sequencing
// Assumes: wake sources and resets are pin-level inputs from other logic/domains
// Notes: gate outputs are enables, high means the domain runs
`timescale 1ns/1ns
`include "smc_regs.vh"
// Overview of operation
// - Sleep only if enable bit set at instruction
// - Decode three mode bits; 100, 101 reserved
// - Mode bits 7,5,4; enable 6; sense 3..0
// - Wake stalls core four cycles past start-up
// - Register file and memory kept across sleep
// - Reset during sleep restarts from reset vector
// - Idle stops only core and program clocks
// - Idle wakes on external and peripheral interrupts
// - Idle or noise mode starts conversion
// - Noise mode halts peripheral, core, program clocks
// - Noise mode wakes on its listed sources
// - Power-down stops oscillator and all clocks
// - Power-down wakes on resets, match, external
// - Power-down wake waits fuse-set restart delay
// - Power-save keeps external timer 2 running
// - Timer 2 undefined without external clock
// - Code 110 with crystal: Standby, six cycles
// - Code 111 with crystal: Extended Standby, six
// - Non-idle modes: only EXT_INTERRUPT_TWO or level EXT_INTERRUPT_ZERO/1
// - Timer clock kept only with external clocking
module smc_ctrl #(
   parameter DELAY_WIDTH = 16,
   parameter [DELAY_WIDTH-1:0] RESTART_CYCLES = 16'd6
) (
   sys_clk,
   rst_n,
   reg_addr,
   reg_wdata,
   reg_wr,
   reg_rd,
   reg_rdata,
   sleep_instr,
   crystal_source,
   timer2_external_clocking,
   converter_enabled,
   ext_irq0,
   ext_irq1,
   ext_irq2,
   twi_match_irq,
   timer2_irq,
   mem_ready_irq,
   conv_done_irq,
   periph_irq,
   ext_reset,
   wdt_reset,
   bod_reset,
   core_clock_en,
   program_memory_clock_en,
   peripheral_clock_en,
   converter_clock_en,
   timer_crystal_clock_en,
   main_osc_en,
   timer_osc_en,
   core_stall,
   conv_start,
   take_reset_vector,
   irq_resume,
   sleeping,
   ext_irq0_sense_lo,
   ext_irq0_sense_hi,
   ext_irq1_sense_lo,
   ext_irq1_sense_hi
);
   input wire sys_clk;
   input wire rst_n;
   input wire [3:0] reg_addr;
   input wire [7:0] reg_wdata;
   input wire reg_wr;
   input wire reg_rd;
   output reg [7:0] reg_rdata;
   input wire sleep_instr;
   input wire crystal_source;
   input wire timer2_external_clocking;
   input wire converter_enabled;
   input wire ext_irq0;
   input wire ext_irq1;
   input wire ext_irq2;
   input wire twi_match_irq;
   input wire timer2_irq;
   input wire mem_ready_irq;
   input wire conv_done_irq;
   input wire periph_irq;
   input wire ext_reset;
   input wire wdt_reset;
   input wire bod_reset;
   output reg core_clock_en;
   output reg program_memory_clock_en;
   output reg peripheral_clock_en;
   output reg converter_clock_en;
   output reg timer_crystal_clock_en;
   output reg main_osc_en;
   output reg timer_osc_en;
   output reg core_stall;
   output reg conv_start;
   output reg take_reset_vector;
   output reg irq_resume;
   output reg sleeping;
   output reg ext_irq0_sense_lo;
   output reg ext_irq0_sense_hi;
   output reg ext_irq1_sense_lo;
   output reg ext_irq1_sense_hi;

   localparam ST_RUN = 2'h0;
   localparam ST_SLEEP = 2'h1;
   localparam ST_RESTART = 2'h2;
   localparam ST_HALT = 2'h3;

   // ==========================================================
   // Input synchronisers
   // ==========================================================
   localparam NSYNC = 11;
   wire [NSYNC-1:0] async_in;
   reg [NSYNC-1:0] sync_a;
   reg [NSYNC-1:0] sync_b;
   assign async_in = {bod_reset, wdt_reset, ext_reset, periph_irq, conv_done_irq,
                      mem_ready_irq, timer2_irq, twi_match_irq, ext_irq2, ext_irq1,
                      ext_irq0};
   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
         always @(posedge sys_clk) begin
            if (!rst_n) begin
               sync_a[gi] <= 1'b0;
               sync_b[gi] <= 1'b0;
            end else begin
               sync_a[gi] <= async_in[gi];
               sync_b[gi] <= sync_a[gi];
            end
         end
      end
   endgenerate
   wire s_irq0 = sync_b[0];
   wire s_irq1 = sync_b[1];
   wire s_irq2 = sync_b[2];
   wire s_twi = sync_b[3];
   wire s_t2 = sync_b[4];
   wire s_mem = sync_b[5];
   wire s_conv = sync_b[6];
   wire s_periph = sync_b[7];
   wire s_any_reset = sync_b[8] | sync_b[9] | sync_b[10];

   // ==========================================================
   // Control register
   // ==========================================================
   reg [7:0] ctrl;
   wire [2:0] sleep_mode_select;
   wire sleep_enable;
   assign sleep_mode_select = {ctrl[`SMC_SM2_BIT], ctrl[`SMC_SM1_BIT],
                               ctrl[`SMC_SM0_BIT]};
   assign sleep_enable = ctrl[`SMC_SE_BIT];

   reg [1:0] state;
   reg [2:0] mode;

   // Reports whether a mode code can really be entered
   function mode_legal;
      input [2:0] m;
      input xtal;
      begin
         case (m)
            `SMC_MODE_IDLE, `SMC_MODE_NOISE, `SMC_MODE_PDOWN, `SMC_MODE_PSAVE:
               mode_legal = 1'b1;
            `SMC_MODE_STBY, `SMC_MODE_XSTBY:
               mode_legal = xtal;
            default:
               mode_legal = 1'b0;
         endcase
      end
   endfunction

   // Level sense means both sense bits of that input are zero
   wire irq0_level = (ctrl[1:0] == 2'h0);
   wire irq1_level = (ctrl[3:2] == 2'h0);
   wire ext_wake_deep = s_irq2 | (s_irq0 & irq0_level) | (s_irq1 & irq1_level);

   reg wake_src;
   always @* begin
      case (mode)
         `SMC_MODE_IDLE:
            wake_src = s_irq0 | s_irq1 | s_irq2 | s_twi | s_t2 | s_mem | s_conv
                       | s_periph;
         `SMC_MODE_NOISE:
            wake_src = ext_wake_deep | s_twi | s_t2 | s_mem | s_conv;
         `SMC_MODE_PSAVE, `SMC_MODE_XSTBY:
            wake_src = ext_wake_deep | s_twi | (s_t2 & timer2_external_clocking);
         default:
            wake_src = ext_wake_deep | s_twi;
      endcase
   end

   // ==========================================================
   // Wake delay counter
   // ==========================================================
   reg dly_load;
   reg [DELAY_WIDTH-1:0] dly_value;
   wire dly_done;
   smc_delay #(.WIDTH(DELAY_WIDTH)) u_delay (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .load(dly_load),
      .load_value(dly_value),
      .done(dly_done)
   );

   // ==========================================================
   // Sleep sequencer
   // ==========================================================
   wire enter_sleep = sleep_instr & sleep_enable
                      & mode_legal(sleep_mode_select, crystal_source);
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         state <= ST_RUN;
         mode <= `SMC_MODE_IDLE;
         dly_load <= 1'b0;
         dly_value <= {DELAY_WIDTH{1'b0}};
         conv_start <= 1'b0;
         take_reset_vector <= 1'b0;
         irq_resume <= 1'b0;
      end else begin
         dly_load <= 1'b0;
         conv_start <= 1'b0;
         take_reset_vector <= 1'b0;
         irq_resume <= 1'b0;
         case (state)
            ST_RUN: begin
               if (enter_sleep) begin
                  state <= ST_SLEEP;
                  mode <= sleep_mode_select;
                  conv_start <= converter_enabled
                     & (sleep_mode_select == `SMC_MODE_IDLE
                        || sleep_mode_select == `SMC_MODE_NOISE);
               end
            end
            ST_SLEEP: begin
               if (s_any_reset) begin
                  state <= ST_RUN;
                  take_reset_vector <= 1'b1;
               end else if (wake_src) begin
                  state <= ST_RESTART;
                  dly_load <= 1'b1;
                  if (mode == `SMC_MODE_STBY || mode == `SMC_MODE_XSTBY)
                     dly_value <= {{(DELAY_WIDTH-8){1'b0}}, `SMC_STBY_CYCLES};
                  else if (mode == `SMC_MODE_IDLE || mode == `SMC_MODE_NOISE)
                     dly_value <= {{(DELAY_WIDTH-1){1'b0}}, 1'b1};
                  else
                     dly_value <= RESTART_CYCLES;
               end
            end
            ST_RESTART: begin
               if (s_any_reset) begin
                  state <= ST_RUN;
                  take_reset_vector <= 1'b1;
               end else if (dly_done) begin
                  state <= ST_HALT;
                  dly_load <= 1'b1;
                  dly_value <= {{(DELAY_WIDTH-8){1'b0}}, `SMC_HALT_CYCLES};
               end
            end
            ST_HALT: begin
               if (s_any_reset) begin
                  state <= ST_RUN;
                  take_reset_vector <= 1'b1;
               end else if (dly_done) begin
                  state <= ST_RUN;
                  irq_resume <= 1'b1;
               end
            end
            default: state <= ST_RUN;
         endcase
      end
   end

   // ==========================================================
   // Clock and oscillator gating
   // ==========================================================
   // Gating only stops clocks; storage keeps its contents because nothing is reset here
   wire in_sleep = (state == ST_SLEEP) | (state == ST_RESTART);
   wire asy_keep = timer2_external_clocking;
   reg n_core, n_prog, n_per, n_conv, n_asy, n_osc, n_tosc;
   always @* begin
      n_core = 1'b1;
      n_prog = 1'b1;
      n_per = 1'b1;
      n_conv = 1'b1;
      n_asy = 1'b1;
      n_osc = 1'b1;
      n_tosc = asy_keep;
      if (in_sleep) begin
         n_core = 1'b0;
         n_prog = 1'b0;
         case (mode)
            `SMC_MODE_IDLE: begin
               n_asy = asy_keep;
            end
            `SMC_MODE_NOISE: begin
               n_per = 1'b0;
               n_asy = asy_keep;
            end
            `SMC_MODE_PSAVE: begin
               n_per = 1'b0;
               n_conv = 1'b0;
               n_osc = 1'b0;
               n_asy = asy_keep;
            end
            `SMC_MODE_STBY: begin
               n_per = 1'b0;
               n_conv = 1'b0;
               n_asy = 1'b0;
               n_tosc = 1'b0;
            end
            `SMC_MODE_XSTBY: begin
               n_per = 1'b0;
               n_conv = 1'b0;
               n_asy = asy_keep;
            end
            default: begin
               n_per = 1'b0;
               n_conv = 1'b0;
               n_asy = 1'b0;
               n_osc = 1'b0;
               n_tosc = 1'b0;
            end
         endcase
      end
   end

   always @(posedge sys_clk) begin
      if (!rst_n) begin
         core_clock_en <= 1'b1;
         program_memory_clock_en <= 1'b1;
         peripheral_clock_en <= 1'b1;
         converter_clock_en <= 1'b1;
         timer_crystal_clock_en <= 1'b0;
         main_osc_en <= 1'b1;
         timer_osc_en <= 1'b0;
         core_stall <= 1'b0;
         sleeping <= 1'b0;
      end else begin
         core_clock_en <= n_core;
         program_memory_clock_en <= n_prog;
         peripheral_clock_en <= n_per;
         converter_clock_en <= n_conv;
         timer_crystal_clock_en <= n_asy & asy_keep;
         main_osc_en <= n_osc;
         timer_osc_en <= n_tosc;
         core_stall <= (state != ST_RUN) | enter_sleep;
         sleeping <= in_sleep;
      end
   end

   // ==========================================================
   // Register port
   // ==========================================================
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         ctrl <= `SMC_CTRL_RESET;
         reg_rdata <= 8'h00;
         ext_irq0_sense_lo <= 1'b0;
         ext_irq0_sense_hi <= 1'b0;
         ext_irq1_sense_lo <= 1'b0;
         ext_irq1_sense_hi <= 1'b0;
      end else begin
         if (reg_wr && reg_addr == `SMC_CTRL_ADDR)
            ctrl <= reg_wdata;
         ext_irq0_sense_lo <= ctrl[0];
         ext_irq0_sense_hi <= ctrl[1];
         ext_irq1_sense_lo <= ctrl[2];
         ext_irq1_sense_hi <= ctrl[3];
         reg_rdata <= 8'h00;
         if (reg_rd) begin
            case (reg_addr)
               `SMC_CTRL_ADDR: reg_rdata <= ctrl;
               `SMC_STAT_ADDR: reg_rdata <= {5'h00, mode_legal(sleep_mode_select,
                                             crystal_source), state};
               default: reg_rdata <= 8'h00;
            endcase
         end
      end
   end
endmodule // smc_ctrl

/* File: smc_regs.vh */
// Purpose: constants for the sleep-mode controller
// Assumes: 8-bit control register, one word address
// Notes: timing counts in core clock cycles
`ifndef SMC_REGS_VH
`define SMC_REGS_VH
`define SMC_CTRL_ADDR 4'h0
`define SMC_STAT_ADDR 4'h1
`define SMC_CTRL_RESET 8'h00
`define SMC_SM2_BIT 7
`define SMC_SE_BIT 6
`define SMC_SM1_BIT 5
`define SMC_SM0_BIT 4
`define SMC_MODE_IDLE 3'h0
`define SMC_MODE_NOISE 3'h1
`define SMC_MODE_PDOWN 3'h2
`define SMC_MODE_PSAVE 3'h3
`define SMC_MODE_STBY 3'h6
`define SMC_MODE_XSTBY 3'h7
`define SMC_HALT_CYCLES 8'h04
`define SMC_STBY_CYCLES 8'h06
`endif

/* File: smc_delay.v */
// Purpose: down counter timing the wake-up delay
// Assumes: load and count on the same clock
// Notes: done is a one-cycle pulse on the clock after the count is down to one
`timescale 1ns/1ns
module smc_delay #(
   parameter WIDTH = 16
) (
   sys_clk,
   rst_n,
   load,
   load_value,
   done
);
   input wire sys_clk;
   input wire rst_n;
   input wire load;
   input wire [WIDTH-1:0] load_value;
   output reg done;
   reg [WIDTH-1:0] count;
   reg running;
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         count <= {WIDTH{1'b0}};
         running <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (load) begin
            count <= load_value;
            running <= 1'b1;
         end else if (running) begin
            if (count <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
               running <= 1'b0;
               done <= 1'b1;
            end else begin
               count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
            end
         end
      end
   end
endmodule // smc_delay

/* File: smc_ctrl_monitor.sv */
// Purpose: port-level checks of the sleep-mode controller
// Assumes: one clock, synchronous active-low reset
// Notes: attached by bind from the bench top
`timescale 1ns/1ns
module smc_ctrl_monitor (
   input logic sys_clk,
   input logic rst_n,
   input logic reg_rd,
   input logic [7:0] reg_rdata,
   input logic timer2_external_clocking,
   input logic core_clock_en,
   input logic program_memory_clock_en,
   input logic peripheral_clock_en,
   input logic main_osc_en,
   input logic timer_crystal_clock_en,
   input logic core_stall,
   input logic conv_start,
   input logic take_reset_vector,
   input logic irq_resume,
   input logic sleeping
);
   // ==========================================
   // Sequences
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   sequence s_asleep_two;
      sleeping && $past(sleeping);
   endsequence
   sequence s_halt_three;
      !$past(sleeping) && !$past(sleeping, 2) && !$past(sleeping, 3);
   endsequence
   // ==========================================
   // Assertions
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside a read answer");
   a_core_gated: assert property (s_asleep_two |-> !core_clock_en && !program_memory_clock_en)
      else $error("core clocks run while asleep");
   a_osc_stall: assert property (!main_osc_en |-> core_stall)
      else $error("oscillator off while core runs");
   a_per_stall: assert property (!peripheral_clock_en |-> core_stall)
      else $error("peripheral clock off while core runs");
   a_timer_ext: assert property (timer_crystal_clock_en |-> $past(timer2_external_clocking))
      else $error("timer clock without external clocking");
   a_resume_halt: assert property (irq_resume |-> s_halt_three ##0 core_stall ##1 !core_stall)
      else $error("resume without halt cycles");
   a_reset_wake: assert property (take_reset_vector |=> !sleeping)
      else $error("still asleep after reset wake");
   a_conv_start: assert property (conv_start |=> sleeping && !$past(sleeping))
      else $error("conversion start away from sleep entry");
endmodule // smc_ctrl_monitor

/* File: smc_core_model.sv */
// Purpose: core and wake-source side of the sleep-mode controller
// Assumes: commands from the bench are one-cycle pulses
// Notes: a wake level is held until the controller answers
`timescale 1ns/1ns
module smc_core_model (
   input logic sys_clk,
   input logic rst_n,
   input logic fire,
   input logic wake_req,
   input logic irq_resume,
   input logic take_reset_vector,
   output logic sleep_instr,
   output logic wake_line
);
   // ==========================================
   // Core and source behaviour
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         sleep_instr <= 1'b0;
         wake_line <= 1'b0;
      end else begin
         sleep_instr <= fire;
         // Short level pulses could be lost in the synchroniser
         if (wake_req)
            wake_line <= 1'b1;
         else if (irq_resume | take_reset_vector)
            wake_line <= 1'b0;
      end
   end
endmodule // smc_core_model

/* File: test_sleep_mode_controller.sv */
// Purpose: self-checking bench for the sleep-mode controller
// Assumes: 10 MHz clock, restart delay of six cycles
// Notes: wake sources share one held line picked by src_sel
`timescale 1ns/1ns
module test_sleep_mode_controller;
   logic sys_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, fire = 0, wake_req = 0;
   logic crystal_source = 0, timer2_external_clocking = 0, converter_enabled = 0;
   logic [3:0] reg_addr = 4'h0, src_sel = 4'h0;
   logic [7:0] reg_wdata = 8'h00, rdv;
   logic [7:0] reg_rdata;
   logic core_clock_en, program_memory_clock_en, peripheral_clock_en, converter_clock_en;
   logic timer_crystal_clock_en, main_osc_en, timer_osc_en, core_stall, conv_start;
   logic take_reset_vector, irq_resume, sleeping, sleep_instr, wake_line;
   logic ext_irq0_sense_lo, ext_irq0_sense_hi, ext_irq1_sense_lo, ext_irq1_sense_hi;
   wire [10:0] src = wake_line ? (11'h001 << src_sel) : 11'h000;
   int error_cnt = 0, n_tests = 0, n_conv = 0, lat;
   smc_ctrl #(.DELAY_WIDTH(16), .RESTART_CYCLES(16'd6)) u_smc_ctrl (.sys_clk, .rst_n,
      .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sleep_instr, .crystal_source,
      .timer2_external_clocking, .converter_enabled, .ext_irq0(src[0]), .ext_irq1(src[1]),
      .ext_irq2(src[2]), .twi_match_irq(src[3]), .timer2_irq(src[4]), .mem_ready_irq(src[5]),
      .conv_done_irq(src[6]), .periph_irq(src[7]), .ext_reset(src[8]), .wdt_reset(src[9]),
      .bod_reset(src[10]), .core_clock_en, .program_memory_clock_en, .peripheral_clock_en,
      .converter_clock_en, .timer_crystal_clock_en, .main_osc_en, .timer_osc_en, .core_stall,
      .conv_start, .take_reset_vector, .irq_resume, .sleeping, .ext_irq0_sense_lo,
      .ext_irq0_sense_hi, .ext_irq1_sense_lo, .ext_irq1_sense_hi);
   smc_core_model u_smc_core_model (.sys_clk, .rst_n, .fire, .wake_req, .irq_resume,
      .take_reset_vector, .sleep_instr, .wake_line);
   // ==========================================
   // Shared tasks
   initial begin
      forever #50 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) if (conv_start === 1'b1) n_conv++;
   task check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a; reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task go_sleep(input logic [7:0] c);
      wr(4'h0, c);
      @(posedge sys_clk) fire <= 1'b1;
      @(posedge sys_clk) fire <= 1'b0;
      cyc(4);
   endtask
   task poke(input logic [3:0] s);
      @(posedge sys_clk);
      src_sel <= s; wake_req <= 1'b1;
      @(posedge sys_clk) wake_req <= 1'b0;
   endtask
   task finish_test;
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // ==========================================
   // Scenarios
   task t_regs;
      rd(4'h0, rdv); check(rdv, 8'h00);
      wr(4'h0, 8'h39); rd(4'h0, rdv); check(rdv, 8'h39);
      check({ext_irq1_sense_hi, ext_irq1_sense_lo, ext_irq0_sense_hi, ext_irq0_sense_lo}, 8'h09);
      rd(4'hf, rdv); check(rdv, 8'h00);
      rd(4'h1, rdv); check(rdv, 8'h04);
      $display("test regs done");
   endtask
   task t_nosleep;
      logic [7:0] cs [4] = '{8'h00, 8'hc0, 8'hd0, 8'he0};
      foreach (cs[i]) begin
         go_sleep(cs[i]);
         check(sleeping, 1'b0);
         check(core_clock_en, 1'b1);
      end
      $display("test no sleep done");
   endtask
   task t_modes;
      logic [2:0] ms [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
      logic [2:0] m;
      int c0;
      crystal_source <= 1'b1;
      foreach (ms[i]) begin
         m = ms[i];
         timer2_external_clocking <= (m != 3'h3);
         converter_enabled <= (m != 3'h1);
         c0 = n_conv;
         go_sleep({m[2], 1'b1, m[1:0], 4'h1});
         check(n_conv - c0, m == 3'h0);
         check(sleeping, 1'b1);
         check({core_clock_en, program_memory_clock_en}, 8'h00);
         check(peripheral_clock_en, m == 3'h0);
         check(converter_clock_en, m <= 3'h1);
         check(main_osc_en, m inside {3'h0, 3'h1, 3'h6, 3'h7});
         check(timer_crystal_clock_en, m inside {3'h0, 3'h1, 3'h7});
         check(timer_osc_en, m inside {3'h0, 3'h1, 3'h7});
         check(core_stall, 1'b1);
         if (m != 3'h0) begin
            poke(4'h7); cyc(12); check(sleeping, 1'b1);
            poke(4'h0); cyc(12); check(sleeping, 1'b1);
         end
         poke(m == 3'h0 ? 4'h7 : m == 3'h1 ? 4'h6 : m == 3'h7 ? 4'h4 : 4'h2);
         lat = 0;
         while (irq_resume !== 1'b1 && lat < 80) begin
            cyc(1); lat++;
         end
         lat = lat - (m <= 3'h1 ? 1 : 6);
         check(lat >= 4 && lat <= 12, 1'b1);
         rd(4'h0, rdv); check(rdv, {m[2], 1'b1, m[1:0], 4'h1});
      end
      $display("test modes done");
   endtask
   task t_reset;
      for (int s = 8; s <= 10; s++) begin
         go_sleep(8'h60);
         poke(s[3:0]);
         lat = 0;
         while (take_reset_vector !== 1'b1 && lat < 20) begin
            cyc(1); lat++;
         end
         check(take_reset_vector, 1'b1);
         check(irq_resume, 1'b0);
         cyc(2); check(sleeping, 1'b0);
      end
      $display("test reset wake done");
   endtask
   initial begin
      cyc(12);
      rst_n <= 1'b1;
      t_regs;
      t_nosleep;
      t_modes;
      t_reset;
      finish_test;
   end
   initial begin
      #500000;
      error_cnt++;
      finish_test;
   end
endmodule // test_sleep_mode_controller
bind smc_ctrl smc_ctrl_monitor u_smc_ctrl_monitor (.sys_clk, .rst_n, .reg_rd, .reg_rdata,
   .timer2_external_clocking, .core_clock_en, .program_memory_clock_en, .peripheral_clock_en,
   .main_osc_en, .timer_crystal_clock_en, .core_stall, .conv_start, .take_reset_vector,
   .irq_resume, .sleeping);
